/* File: hdl/aec_map.vh */
// Register map, field layout and constants of the auto exposure controller
`ifndef AEC_MAP_VH
`define AEC_MAP_VH
// Register byte offsets
`define AEC_A_CTRL 8'h00
`define AEC_A_EXPMAN 8'h04
`define AEC_A_GAINMAN 8'h08
`define AEC_A_EXPLO 8'h0c
`define AEC_A_EXPHI 8'h10
`define AEC_A_GAINLIM 8'h14
`define AEC_A_TARGET 8'h18
`define AEC_A_DAMPEV 8'h1c
`define AEC_A_ROIPOS 8'h20
`define AEC_A_ROISIZE 8'h24
`define AEC_A_IMGSIZE 8'h28
`define AEC_A_STATUS 8'h2c
`define AEC_A_EXPOUT 8'h30
`define AEC_A_GAINOUT 8'h34
// Control fields
`define AEC_F_EXPAUTO 1:0
`define AEC_F_GAINAUTO 3:2
`define AEC_F_TGTAUTO 4
`define AEC_F_PRIO 5
`define AEC_F_LIGHT 7:6
`define AEC_F_METER 9:8
`define AEC_F_ROIEN 10
`define AEC_F_OWNER 12:11
// Other fields
`define AEC_F_LO10 9:0
`define AEC_F_HI10 25:16
`define AEC_F_TVAL 6:0
`define AEC_F_TLO 14:8
`define AEC_F_THI 22:16
`define AEC_F_DAMP 8:0
`define AEC_F_EV 20:16
`define AEC_F_LOW12 11:0
`define AEC_F_HIGH12 27:16
// Enumerations
`define AEC_AUTO_OFF 2'h0
`define AEC_AUTO_ONCE 2'h1
`define AEC_AUTO_CONT 2'h2
`define AEC_LIT_NORM 2'h0
`define AEC_LIT_BACK 2'h1
`define AEC_LIT_FRONT 2'h2
`define AEC_MET_AVG 2'h0
`define AEC_MET_SPOT 2'h1
`define AEC_MET_PART 2'h2
`define AEC_OWN_AE 2'h0
// Reset values and limits
`define AEC_EXP_MIN 24'h00_0001
`define AEC_EXP_MAX 24'hff_ffff
`define AEC_EXP_FIX_US 24'h00_1388
`define AEC_EXP_MAN_RST 24'h00_2710
`define AEC_GAIN_MIN 10'h000
`define AEC_GAIN_MAX 10'h3ff
`define AEC_TGT_RST 7'h32
`define AEC_PCT_MAX 7'h64
`define AEC_DAMP_RST 9'h080
`define AEC_DAMP_ONE 9'h100
`define AEC_EV_MIN 5'h17
`define AEC_EV_MAX 5'h09
`define AEC_EV_BIAS 5'h09
`define AEC_IMG_W_RST 12'h280
`define AEC_IMG_H_RST 12'h1e0
// Built-in target levels in percent
`define AEC_BASE_AVG 7'h32
`define AEC_BASE_SPOT 7'h2d
`define AEC_BASE_PART 7'h30
`define AEC_BASE_BACK 7'h37
`define AEC_BASE_FRONT 7'h28
// Arithmetic constants
`define AEC_PIX_MAX 8'hff
`define AEC_TOL 18'h0_01fe
`define AEC_FRAC0 9'h100
`define AEC_FRAC1 9'h143
`define AEC_FRAC2 9'h196
`define AEC_SPOT_MUL 8'h2b
`define AEC_PART_MUL 8'h55
`define AEC_WEIGHT 3'h4
`define AEC_DIV_TOP 3'h7
`endif

/* File: hdl/aec_meter.v */
// Weighted brightness accumulator over a metering window
`timescale 1ns/1ps
`default_nettype none
`include "aec_map.vh"
module aec_meter #(
  parameter SW = 32,
  parameter CW = 24,
  parameter XW = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Pixel stream
  input wire frame_start,
  input wire frame_end,
  input wire pix_valid,
  input wire [XW-1:0] pix_x,
  input wire [XW-1:0] pix_y,
  input wire [7:0] pix_data,
  // Window and weighting
  input wire [XW:0] x0,
  input wire [XW:0] x1,
  input wire [XW:0] y0,
  input wire [XW:0] y1,
  input wire [1:0] wmode,
  input wire [7:0] ref_level,
  // Results
  output reg [SW-1:0] sum_out,
  output reg [CW-1:0] cnt_out,
  output reg done
);
  reg [SW-1:0] sum;
  reg [CW-1:0] cnt;
  wire inwin;
  reg [2:0] wt;

  assign inwin = pix_valid && ({1'b0, pix_x} >= x0) &&
                 ({1'b0, pix_x} < x1) && ({1'b0, pix_y} >= y0) &&
                 ({1'b0, pix_y} < y1);

  // Dark pixels weigh more under backlight, bright ones under frontlight
  always @* begin
    wt = 3'h1;
    if (wmode == `AEC_LIT_BACK && pix_data < ref_level)
      wt = `AEC_WEIGHT;
    if (wmode == `AEC_LIT_FRONT && pix_data > ref_level)
      wt = `AEC_WEIGHT;
  end

  // Accumulate within the frame, latch at its end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum <= {SW{1'b0}};
      cnt <= {CW{1'b0}};
      sum_out <= {SW{1'b0}};
      cnt_out <= {CW{1'b0}};
      done <= 1'b0;
    end else begin
      done <= frame_end;
      if (frame_start) begin
        sum <= {SW{1'b0}};
        cnt <= {CW{1'b0}};
      end else if (inwin) begin
        sum <= sum + pix_data * wt;
        cnt <= cnt + wt;
      end
      if (frame_end) begin
        sum_out <= sum;
        cnt_out <= cnt;
      end
    end
  end
endmodule // aec_meter
`default_nettype wire

/* File: hdl/aec_ctrl.v */
// Auto exposure control loop with APB register file
// Function
// - Loop runs only when exposure or gain automated
// - Exposure/gain follow measured versus target average
// - Continuous target uses software percentage value
// - Target off: device picks target from modes
// - Automatic exposure kept inside microsecond limits
// - Automatic gain kept inside decibel limits
// - Target average kept inside percent limits
// - Damping 0.0 to 1.0, reset 0.5
// - Priority decides which quantity adjusts first
// - Gain priority: gain 0 dB, exposure first
// - Exposure priority: exposure 5 ms, gain first
// - Backlight, frontlight, normal; normal after reset
// - Backlight weights metering toward dark subject
// - Frontlight weights metering toward bright subject
// - Metering selectable only under normal lighting
// - Average metering weighs all pixels equally
// - Spot meters central area of about 3%
// - Partial meters central area of about 11%
// - Metering region never exceeds captured image
// - EV compensation -3..3 in thirds, reset 0
`timescale 1ns/1ps
`default_nettype none
`include "aec_map.vh"
module aec_ctrl #(
  parameter XW = 12,
  parameter EXP_SH = 2,
  parameter GAIN_SH = 6
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pixel statistics stream
  input wire frame_start,
  input wire frame_end,
  input wire pix_valid,
  input wire [XW-1:0] pix_x,
  input wire [XW-1:0] pix_y,
  input wire [7:0] pix_data,
  // Sensor exposure and gain
  output reg [23:0] exp_time_us,
  output reg [9:0] gain_db8,
  output reg exp_update
);
  localparam S_IDLE = 2'd0;
  localparam S_DIV = 2'd1;
  localparam S_CALC = 2'd2;

  reg [1:0] exp_auto, gain_auto, lighting, metering, owner;
  reg tgt_auto, prio, roi_en, act_d, conv;
  reg [23:0] exp_man, exp_lo, exp_hi;
  reg [9:0] gain_man, gain_lo, gain_hi;
  reg [6:0] tgt_pct, tgt_lo, tgt_hi;
  reg [8:0] damp;
  reg [4:0] ev;
  reg [XW-1:0] roi_x, roi_y, roi_w, roi_h, img_w, img_h;
  reg [7:0] avg;
  reg [1:0] st;
  reg [2:0] bit_i;
  reg [31:0] rem, dsh;
  reg [7:0] quo;
  reg [31:0] rd_mux;
  reg hit;

  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite & pready;
  wire wr_ctrl = wr_acc && paddr == `AEC_A_CTRL;
  wire ea = exp_auto != `AEC_AUTO_OFF;
  wire ga = gain_auto != `AEC_AUTO_OFF;
  wire active = ea | ga;

  // Effective limits; an inverted pair falls back to full range
  wire [23:0] elo = (exp_lo <= exp_hi) ? exp_lo : `AEC_EXP_MIN;
  wire [23:0] ehi = (exp_lo <= exp_hi) ? exp_hi : `AEC_EXP_MAX;
  wire [9:0] glo = (gain_lo <= gain_hi) ? gain_lo : `AEC_GAIN_MIN;
  wire [9:0] ghi = (gain_lo <= gain_hi) ? gain_hi : `AEC_GAIN_MAX;
  wire tlim_ok = tgt_lo <= tgt_hi;

  // Read multiplexer and address decode
  always @* begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `AEC_A_CTRL: rd_mux = {19'h0_0000, owner, roi_en, metering,
                             lighting, prio, tgt_auto, gain_auto,
                             exp_auto};
      `AEC_A_EXPMAN: rd_mux = {8'h00, exp_man};
      `AEC_A_GAINMAN: rd_mux = {22'h00_0000, gain_man};
      `AEC_A_EXPLO: rd_mux = {8'h00, exp_lo};
      `AEC_A_EXPHI: rd_mux = {8'h00, exp_hi};
      `AEC_A_GAINLIM: rd_mux = {6'h00, gain_hi, 6'h00, gain_lo};
      `AEC_A_TARGET: rd_mux = {9'h000, tgt_hi, 1'b0, tgt_lo,
                               1'b0, tgt_pct};
      `AEC_A_DAMPEV: rd_mux = {11'h000, ev, 7'h00, damp};
      `AEC_A_ROIPOS: rd_mux = {4'h0, roi_y, 4'h0, roi_x};
      `AEC_A_ROISIZE: rd_mux = {4'h0, roi_h, 4'h0, roi_w};
      `AEC_A_IMGSIZE: rd_mux = {4'h0, img_h, 4'h0, img_w};
      `AEC_A_STATUS: rd_mux = {21'h00_0000, st != S_IDLE, active,
                               conv, avg};
      `AEC_A_EXPOUT: rd_mux = {8'h00, exp_time_us};
      `AEC_A_GAINOUT: rd_mux = {22'h00_0000, gain_db8};
      default: hit = 1'b0;
    endcase
  end

  // APB answer: one access cycle, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Metering window selection
  reg [XW:0] x0, x1, y0, y1, rx1, ry1;
  reg [XW+7:0] pw, ph;
  always @* begin
    pw = img_w * ((metering == `AEC_MET_SPOT) ? `AEC_SPOT_MUL
                                                 : `AEC_PART_MUL);
    ph = img_h * ((metering == `AEC_MET_SPOT) ? `AEC_SPOT_MUL
                                                 : `AEC_PART_MUL);
    rx1 = {1'b0, roi_x} + {1'b0, roi_w};
    ry1 = {1'b0, roi_y} + {1'b0, roi_h};
    x0 = {(XW+1){1'b0}};
    y0 = {(XW+1){1'b0}};
    x1 = {1'b0, img_w};
    y1 = {1'b0, img_h};
    if (roi_en && owner == `AEC_OWN_AE) begin
      x0 = (roi_x < img_w) ? {1'b0, roi_x} : {1'b0, img_w};
      y0 = (roi_y < img_h) ? {1'b0, roi_y} : {1'b0, img_h};
      x1 = (rx1 < {1'b0, img_w}) ? rx1 : {1'b0, img_w};
      y1 = (ry1 < {1'b0, img_h}) ? ry1 : {1'b0, img_h};
    end else if (lighting == `AEC_LIT_NORM &&
                 metering != `AEC_MET_AVG) begin
      // Centred box: w/6 by h/6 for spot, w/3 by h/3 for partial
      x0 = ({1'b0, img_w} - {1'b0, pw[XW+7:8]}) >> 1;
      y0 = ({1'b0, img_h} - {1'b0, ph[XW+7:8]}) >> 1;
      x1 = x0 + {1'b0, pw[XW+7:8]};
      y1 = y0 + {1'b0, ph[XW+7:8]};
    end
  end

  wire [31:0] m_sum;
  wire [23:0] m_cnt;
  wire m_done;

  aec_meter #(.SW(32), .CW(24), .XW(XW)) u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .pix_valid(pix_valid),
    .pix_x(pix_x),
    .pix_y(pix_y),
    .pix_data(pix_data),
    .x0(x0),
    .x1(x1),
    .y0(y0),
    .y1(y1),
    .wmode(lighting),
    .ref_level(avg),
    .sum_out(m_sum),
    .cnt_out(m_cnt),
    .done(m_done)
  );

  // Target level: software value or mode-dependent built-in value
  reg [6:0] t_pct;
  always @* begin
    if (tgt_auto)
      t_pct = tgt_pct;
    else if (lighting == `AEC_LIT_BACK)
      t_pct = `AEC_BASE_BACK;
    else if (lighting == `AEC_LIT_FRONT)
      t_pct = `AEC_BASE_FRONT;
    else if (metering == `AEC_MET_SPOT)
      t_pct = `AEC_BASE_SPOT;
    else if (metering == `AEC_MET_PART)
      t_pct = `AEC_BASE_PART;
    else
      t_pct = `AEC_BASE_AVG;
  end

  // EV compensation: scale by 2^(ev/3) as fraction times shift
  wire [4:0] ev_k = ev + `AEC_EV_BIAS;
  wire [4:0] ev_q = ev_k / 5'd3;
  wire [4:0] ev_r = ev_k % 5'd3;
  wire [8:0] frac = (ev_r == 5'd0) ? `AEC_FRAC0 :
                    (ev_r == 5'd1) ? `AEC_FRAC1 : `AEC_FRAC2;
  wire [15:0] t_base = t_pct * `AEC_PIX_MAX;
  wire [24:0] t_mul = t_base * frac;
  wire [27:0] t_ev = (ev_q < 5'd3) ? ({3'h0, t_mul} >> (5'd3 - ev_q))
                                    : ({3'h0, t_mul} << (ev_q - 5'd3));
  wire [17:0] t_lo = tgt_lo * `AEC_PIX_MAX;
  wire [17:0] t_hi = tgt_hi * `AEC_PIX_MAX;
  wire [17:0] t_top = `AEC_PCT_MAX * `AEC_PIX_MAX;
  reg [17:0] t_fin;
  always @* begin
    t_fin = (t_ev[27:8] > {2'h0, t_top}) ? t_top : t_ev[25:8];
    if (tlim_ok && t_fin < t_lo)
      t_fin = t_lo;
    if (tlim_ok && t_fin > t_hi)
      t_fin = t_hi;
  end

  // Error, damping and step sizes
  wire [17:0] m_sc = quo * `AEC_PCT_MAX;
  wire signed [18:0] err = $signed({1'b0, t_fin}) -
                           $signed({1'b0, m_sc});
  wire [9:0] undamp = {1'b0, `AEC_DAMP_ONE} - {1'b0, damp};
  wire signed [29:0] prod = err * $signed({1'b0, undamp});
  wire signed [29:0] step = prod >>> 8;
  // Sign-extend the step to the full update width before shifting
  wire signed [31:0] step_x = {{2{step[29]}}, step};
  wire up = ~err[18];
  wire conv_now = (err[18] ? -err : err) <= $signed({1'b0, `AEC_TOL});
  wire signed [31:0] dexp = step_x <<< EXP_SH;
  wire signed [31:0] dgain = step_x >>> GAIN_SH;
  wire signed [31:0] ne = $signed({8'h00, exp_time_us}) + dexp;
  wire signed [31:0] ng = $signed({22'h00_0000, gain_db8}) + dgain;
  wire [23:0] e_new = (ne < $signed({8'h00, elo})) ? elo :
                      (ne > $signed({8'h00, ehi})) ? ehi
                      : ne[23:0];
  wire [9:0] g_new = (ng < $signed({22'h0, glo})) ? glo :
                     (ng > $signed({22'h0, ghi})) ? ghi
                     : ng[9:0];
  wire [23:0] e_fix = (`AEC_EXP_FIX_US < elo) ? elo :
                      (`AEC_EXP_FIX_US > ehi) ? ehi : `AEC_EXP_FIX_US;

  // Which quantity this update moves
  reg sel_e, sel_g;
  always @* begin
    sel_e = ea & ~ga;
    sel_g = ga & ~ea;
    if (ea & ga) begin
      if (!prio)
        sel_e = up ? (exp_time_us < ehi) : (gain_db8 <= glo);
      else
        sel_e = up ? (gain_db8 >= ghi) : (exp_time_us > e_fix);
      sel_g = ~sel_e;
    end
  end

  // Frame sequencer: 8-step divide, then one update cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      bit_i <= 3'h0;
      rem <= 32'h0000_0000;
      dsh <= 32'h0000_0000;
      quo <= 8'h00;
      avg <= 8'h00;
      conv <= 1'b0;
    end else begin
      case (st)
        S_IDLE: begin
          if (m_done && m_cnt != 24'h00_0000) begin
            rem <= m_sum;
            dsh <= {1'b0, m_cnt, 7'h00};
            bit_i <= `AEC_DIV_TOP;
            quo <= 8'h00;
            st <= S_DIV;
          end
        end
        S_DIV: begin
          if (rem >= dsh) begin
            rem <= rem - dsh;
            quo[bit_i] <= 1'b1;
          end
          dsh <= dsh >> 1;
          bit_i <= bit_i - 3'h1;
          if (bit_i == 3'h0)
            st <= S_CALC;
        end
        S_CALC: begin
          avg <= quo;
          conv <= conv_now;
          st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // Exposure and gain outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_time_us <= `AEC_EXP_MAN_RST;
      gain_db8 <= `AEC_GAIN_MIN;
      exp_update <= 1'b0;
      act_d <= 1'b0;
    end else begin
      act_d <= active;
      exp_update <= 1'b0;
      if (!ea)
        exp_time_us <= exp_man;
      if (!ga)
        gain_db8 <= gain_man;
      if (active && !act_d) begin
        // Loop entry: seed the automated quantities
        if (ea)
          exp_time_us <= (ga && prio) ? e_fix : exp_man;
        if (ga)
          gain_db8 <= (ea && !prio) ? glo : gain_man;
      end else if (st == S_CALC && active) begin
        exp_update <= 1'b1;
        if (sel_e)
          exp_time_us <= e_new;
        if (sel_g)
          gain_db8 <= g_new;
      end
    end
  end

  // Software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_auto <= `AEC_AUTO_OFF;
      gain_auto <= `AEC_AUTO_OFF;
      tgt_auto <= 1'b0;
      prio <= 1'b0;
      lighting <= `AEC_LIT_NORM;
      metering <= `AEC_MET_AVG;
      roi_en <= 1'b0;
      owner <= `AEC_OWN_AE;
      exp_man <= `AEC_EXP_MAN_RST;
      gain_man <= `AEC_GAIN_MIN;
      exp_lo <= `AEC_EXP_MIN;
      exp_hi <= `AEC_EXP_MAX;
      gain_lo <= `AEC_GAIN_MIN;
      gain_hi <= `AEC_GAIN_MAX;
      tgt_pct <= `AEC_TGT_RST;
      tgt_lo <= 7'h00;
      tgt_hi <= `AEC_PCT_MAX;
      damp <= `AEC_DAMP_RST;
      ev <= 5'h00;
      roi_x <= {XW{1'b0}};
      roi_y <= {XW{1'b0}};
      roi_w <= `AEC_IMG_W_RST;
      roi_h <= `AEC_IMG_H_RST;
      img_w <= `AEC_IMG_W_RST;
      img_h <= `AEC_IMG_H_RST;
    end else begin
      // Single-shot modes return to off once the target is met
      if (st == S_CALC && conv_now && active && !wr_ctrl) begin
        if (exp_auto == `AEC_AUTO_ONCE)
          exp_auto <= `AEC_AUTO_OFF;
        if (gain_auto == `AEC_AUTO_ONCE)
          gain_auto <= `AEC_AUTO_OFF;
      end
      if (wr_acc) begin
        case (paddr)
          `AEC_A_CTRL: begin
            exp_auto <= pwdata[`AEC_F_EXPAUTO];
            gain_auto <= pwdata[`AEC_F_GAINAUTO];
            tgt_auto <= pwdata[`AEC_F_TGTAUTO];
            prio <= pwdata[`AEC_F_PRIO];
            lighting <= pwdata[`AEC_F_LIGHT];
            if (pwdata[`AEC_F_LIGHT] == `AEC_LIT_NORM)
              metering <= pwdata[`AEC_F_METER];
            roi_en <= pwdata[`AEC_F_ROIEN];
            owner <= pwdata[`AEC_F_OWNER];
          end
          `AEC_A_EXPMAN: exp_man <= pwdata[23:0];
          `AEC_A_GAINMAN: gain_man <= pwdata[`AEC_F_LO10];
          `AEC_A_EXPLO: exp_lo <= pwdata[23:0];
          `AEC_A_EXPHI: exp_hi <= pwdata[23:0];
          `AEC_A_GAINLIM: begin
            gain_lo <= pwdata[`AEC_F_LO10];
            gain_hi <= pwdata[`AEC_F_HI10];
          end
          `AEC_A_TARGET: begin
            tgt_pct <= (pwdata[`AEC_F_TVAL] > `AEC_PCT_MAX) ?
                       `AEC_PCT_MAX : pwdata[`AEC_F_TVAL];
            tgt_lo <= pwdata[`AEC_F_TLO];
            tgt_hi <= pwdata[`AEC_F_THI];
          end
          `AEC_A_DAMPEV: begin
            damp <= (pwdata[`AEC_F_DAMP] > `AEC_DAMP_ONE) ?
                    `AEC_DAMP_ONE : pwdata[`AEC_F_DAMP];
            if ($signed(pwdata[`AEC_F_EV]) < $signed(`AEC_EV_MIN))
              ev <= `AEC_EV_MIN;
            else if ($signed(pwdata[`AEC_F_EV]) > $signed(`AEC_EV_MAX))
              ev <= `AEC_EV_MAX;
            else
              ev <= pwdata[`AEC_F_EV];
          end
          `AEC_A_ROIPOS: begin
            roi_x <= pwdata[`AEC_F_LOW12];
            roi_y <= pwdata[`AEC_F_HIGH12];
          end
          `AEC_A_ROISIZE: begin
            roi_w <= pwdata[`AEC_F_LOW12];
            roi_h <= pwdata[`AEC_F_HIGH12];
          end
          `AEC_A_IMGSIZE: begin
            img_w <= pwdata[`AEC_F_LOW12];
            img_h <= pwdata[`AEC_F_HIGH12];
          end
          default: ;
        endcase
      end
    end
  end
endmodule // aec_ctrl
`default_nettype wire

/* File: dv/aec_ctrl_asserts.sv */
// Port level checks of the auto exposure controller
`timescale 1ns/1ps
`default_nettype none
module aec_ctrl_asserts (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Frame end and loop outputs
  input wire frame_end,
  input wire [23:0] exp_time_us,
  input wire [9:0] gain_db8,
  input wire exp_update
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // Register access answers in one access cycle
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_needs_sel: assert property (!psel |=> !pready)
    else $error("pready without select");
  a_err_unmapped: assert property (pready && paddr > 8'h34 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= 8'h34
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  // One update per frame, a fixed time after the frame closes
  a_update_latency: assert property (exp_update |-> $past(frame_end, 11))
    else $error("update not 11 cycles after frame end");
  a_update_spacing: assert property (exp_update |=> !exp_update [*8])
    else $error("updates too close");
endmodule // aec_ctrl_asserts
bind aec_ctrl aec_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_end(frame_end), .exp_time_us(exp_time_us),
  .gain_db8(gain_db8), .exp_update(exp_update));
`default_nettype wire

/* File: dv/aec_sensor_model.sv */
// Behavioural sensor: frames whose brightness follows exposure and gain
`timescale 1ns/1ps
`default_nettype none
module aec_sensor_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scene control
  input wire logic run,
  input wire logic [7:0] scene,
  // Settings from the controller
  input wire logic [23:0] exp_time_us,
  input wire logic [9:0] gain_db8,
  // Pixel stream
  output logic frame_start,
  output logic frame_end,
  output logic pix_valid,
  output logic [11:0] pix_x,
  output logic [11:0] pix_y,
  output logic [7:0] pix_data
);
  logic [7:0] cnt;
  logic [7:0] p;
  logic [31:0] lvl;
  // Frame sequencer: start, 128 pixels, end, idle gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt <= 8'h00;
    else if (cnt != 8'h00 || run)
      cnt <= (cnt == 8'h9f) ? 8'h00 : cnt + 8'h01;
  end
  // Level saturates; idle data toggles so nothing stale looks valid
  always_comb begin
    p = cnt - 8'h02;
    lvl = ({24'h0, scene} * {8'h0, exp_time_us}) >> 12;
    lvl = lvl + {22'h0, gain_db8} * {28'h0, scene[7:4]} / 8;
    frame_start = (cnt == 8'h01);
    frame_end = (cnt == 8'h8c);
    pix_valid = (cnt >= 8'h02 && cnt <= 8'h81);
    pix_x = {8'h0, p[3:0]};
    pix_y = {9'h0, p[6:4]};
    pix_data = !pix_valid ? (cnt ^ 8'h5a) : (lvl > 255) ? 8'hff : lvl[7:0];
  end
endmodule // aec_sensor_model
`default_nettype wire

/* File: dv/auto_exposure_controller_bench.sv */
// Self-checking bench of the auto exposure controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module auto_exposure_controller_bench;
  typedef struct {
    logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic er;
  } aec_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic run = 1'b0;
  logic [7:0] scene = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, frame_start, frame_end, pix_valid, exp_update;
  wire [11:0] pix_x, pix_y;
  wire [7:0] pix_data;
  wire [23:0] exp_time_us;
  wire [9:0] gain_db8;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ups;
  logic [31:0] rd;
  logic er;
  // Reset values, clamps and refusals: address, write, data, read, error
  aec_row_t rows [24] = '{
    '{8'h00, 0, 0, 32'h0000_0000, 0}, '{8'h04, 0, 0, 32'h0000_2710, 0},
    '{8'h08, 0, 0, 32'h0000_0000, 0}, '{8'h0c, 0, 0, 32'h0000_0001, 0},
    '{8'h10, 0, 0, 32'h00ff_ffff, 0}, '{8'h14, 0, 0, 32'h03ff_0000, 0},
    '{8'h18, 0, 0, 32'h0064_0032, 0}, '{8'h1c, 0, 0, 32'h0000_0080, 0},
    '{8'h24, 0, 0, 32'h01e0_0280, 0}, '{8'h28, 0, 0, 32'h01e0_0280, 0},
    '{8'h20, 1, 32'h0002_0003, 32'h0002_0003, 0},
    '{8'h24, 1, 32'h0004_0005, 32'h0004_0005, 0},
    '{8'h40, 0, 0, 32'h0000_0000, 1}, '{8'h40, 1, 5, 32'h0000_0000, 1},
    '{8'h1c, 1, 32'h000c_01ff, 32'h0009_0100, 0},
    '{8'h1c, 1, 32'h0010_0000, 32'h0017_0000, 0},
    '{8'h1c, 1, 32'h0000_0080, 32'h0000_0080, 0},
    '{8'h18, 1, 32'h0064_0078, 32'h0064_0064, 0},
    '{8'h18, 1, 32'h0064_0032, 32'h0064_0032, 0},
    '{8'h00, 1, 32'h0000_0140, 32'h0000_0040, 0},
    '{8'h00, 1, 32'h0000_0100, 32'h0000_0100, 0},
    '{8'h00, 1, 32'h0000_0080, 32'h0000_0180, 0},
    '{8'h00, 1, 32'h0000_0000, 32'h0000_0000, 0},
    '{8'h04, 1, 32'h0000_04d2, 32'h0000_04d2, 0}};
  aec_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .frame_end(frame_end),
    .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
    .pix_data(pix_data), .exp_time_us(exp_time_us), .gain_db8(gain_db8),
    .exp_update(exp_update));
  aec_sensor_model u_sensor (.pclk(pclk), .presetn(presetn), .run(run),
    .scene(scene), .exp_time_us(exp_time_us), .gain_db8(gain_db8),
    .frame_start(frame_start), .frame_end(frame_end),
    .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
    .pix_data(pix_data));
  // 50 MHz clock
  initial begin
    forever #10 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    if (t >= 20)
      n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Run for a number of cycles, counting loop updates
  task automatic wait_ups(input int n);
    ups = 0;
    repeat (n) begin
      @(posedge pclk);
      if (exp_update === 1'b1)
        ups++;
    end
  endtask
  // Counts and verdict
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    `CHK("rst exp", 24'h00_2710, exp_time_us)
    `CHK("rst gain", 10'h000, gain_db8)
    `CHK("rst ready", 1'b0, pready)
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].w)
        apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("reg", rows[i].e, rd)
      `CHK("err", rows[i].er, er)
    end
    run <= 1'b1;
    scene <= 8'h80;
    wait_ups(600);
    `CHK("manual ups", 0, ups)
    `CHK("manual exp", 24'h00_04d2, exp_time_us)
    apb(1'b1, 8'h0c, 32'h0000_1000);
    apb(1'b1, 8'h10, 32'h0000_3000);
    apb(1'b1, 8'h00, 32'h0000_0012);
    scene <= 8'h00;
    wait_ups(8000);
    `CHK("auto ups", 1'b1, ups > 0)
    `CHK("exp hi", 24'h00_3000, exp_time_us)
    scene <= 8'hff;
    wait_ups(8000);
    `CHK("exp lo", 24'h00_1000, exp_time_us)
    run <= 1'b0;
    wait_ups(200);
    // Leave the loop first so that the new priority seeds on entry
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_003a);
    wait_ups(4);
    `CHK("prio exp", 24'h00_1388, exp_time_us)
    run <= 1'b1;
    scene <= 8'h00;
    wait_ups(3000);
    `CHK("gain up", 1'b1, gain_db8 != 10'h000)
    run <= 1'b0;
    wait_ups(200);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_001a);
    wait_ups(4);
    `CHK("prio gain", 10'h000, gain_db8)
    // Reset in mid-run, then a first access right after release
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK("rerst exp", 24'h00_2710, exp_time_us)
    `CHK("rerst ready", 1'b0, pready)
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK("rerst ctrl", 32'h0000_0000, rd)
    final_report();
  end
endmodule // auto_exposure_controller_bench
`default_nettype wire
